// ==== bench/cgi_geometry_props.sv ====
module cgi_geometry_props (
    input wire        clk_sys, resetn, rd_en, wr_en,
    input wire [2:0]  rd_opcode2,
    input wire [31:0] wr_data, rd_data,
    input wire        dcache_absent_flag, icache_absent_flag,
    input wire        data_ram_absent_flag, instr_ram_absent_flag,
    input wire [3:0]  icache_capacity_code, data_ram_capacity_code,
    input wire [3:0]  instr_ram_capacity_code,
    input wire        rd_valid, rd_hit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Geometry passes two flops and a steadiness stage: depth four.
    property p_valid; rd_en |=> rd_valid; endproperty
    a_valid: assert property (p_valid) else $error("no answer");
    property p_idle; !rd_en |=> !rd_valid && rd_data == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stray word");
    property p_hit; rd_valid |-> rd_hit == ($past(rd_opcode2) == 3'h1
        || $past(rd_opcode2) == 3'h2); endproperty
    a_hit: assert property (p_hit) else $error("hit wrong");
    property p_miss; rd_valid && !rd_hit |-> rd_data == 32'h0; endproperty
    a_miss: assert property (p_miss) else $error("miss data");
    property p_dc; rd_hit && $past(rd_opcode2) == 3'h1 |-> rd_data[14:12]
        == {$past(dcache_absent_flag, 4), 2'h2}; endproperty
    a_dc: assert property (p_dc) else $error("dcache bits");
    property p_ic; rd_hit && $past(rd_opcode2) == 3'h1 |-> rd_data[9:0] ==
        ($past(icache_absent_flag, 4) ? 10'h6 :
        {$past(icache_capacity_code, 4), 6'h12}); endproperty
    a_ic: assert property (p_ic) else $error("icache bits");
    property p_res; rd_hit && $past(rd_opcode2) == 3'h1 |->
        rd_data[31:15] == 17'h0 && rd_data[11:10] == 2'h0; endproperty
    a_res: assert property (p_res) else $error("reserved set");
    property p_ram; rd_hit && $past(rd_opcode2) == 3'h2 |-> rd_data ==
        {10'h0, $past(data_ram_capacity_code, 4), 3'h0,
        $past(data_ram_absent_flag, 4), 4'h0,
        $past(instr_ram_capacity_code, 4), 3'h0,
        $past(instr_ram_absent_flag, 4), 2'h0}; endproperty
    a_ram: assert property (p_ram) else $error("ram word");
endmodule // cgi_geometry_props
bind cgi_geometry_regs cgi_geometry_props i_cgi_geometry_props (
    .clk_sys                 (clk_sys),
    .resetn                  (resetn),
    .rd_en                   (rd_en),
    .wr_en                   (wr_en),
    .rd_opcode2              (rd_opcode2),
    .wr_data                 (wr_data),
    .rd_data                 (rd_data),
    .dcache_absent_flag      (dcache_absent_flag),
    .icache_absent_flag      (icache_absent_flag),
    .data_ram_absent_flag    (data_ram_absent_flag),
    .instr_ram_absent_flag   (instr_ram_absent_flag),
    .icache_capacity_code    (icache_capacity_code),
    .data_ram_capacity_code  (data_ram_capacity_code),
    .instr_ram_capacity_code (instr_ram_capacity_code),
    .rd_valid                (rd_valid),
    .rd_hit                  (rd_hit)
);

// ==== bench/cgi_geometry_regs_tb.sv ====
module cgi_geometry_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0, resetn = 0, rd_en = 0, wr_en = 0;
    logic        dca = 0, icache_ways_code = 0, dra = 0, ira = 0, rd_valid, rd_hit;
    logic [2:0]  op = 0;
    logic [3:0]  icc = 0, drc = 0, irc = 0;
    logic [31:0] wd = 0, rd_data;
    int          err_count = 0, n_tests = 0;
    cgi_geometry_regs i_cgi_geometry_regs (.clk_sys(clk_sys),
        .resetn(resetn), .rd_en(rd_en), .rd_opcode2(op), .wr_en(wr_en),
        .wr_data(wd), .dcache_absent_flag(dca), .icache_absent_flag(icache_ways_code),
        .icache_capacity_code(icc), .data_ram_absent_flag(dra),
        .data_ram_capacity_code(drc), .instr_ram_absent_flag(ira),
        .instr_ram_capacity_code(irc), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_hit(rd_hit));
    initial forever #2.5 clk_sys = ~clk_sys;
    function automatic logic [33:0] exp_word();
        if (op == 3'h1)
            return {2'h3, 17'h0, dca, 4'h8, icache_ways_code ? 10'h6 : {icc, 6'h12}};
        if (op == 3'h2)
            return {2'h3, 10'h0, drc, 3'h0, dra, 4'h0, irc, 3'h0, ira, 2'h0};
        return {2'h2, 32'h0};
    endfunction
    function automatic logic [3:0] cap();
        int k = $urandom % 10;
        return (k == 0) ? 4'h0 : 4'(k + 2);
    endfunction
    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Inputs pass two flops and a steadiness stage: wait four edges.
    task setg(input logic [15:0] v);
        @(posedge clk_sys) {dca, icache_ways_code, dra, ira, icc, drc, irc} <= v;
        repeat (4) @(posedge clk_sys);
    endtask
    task rd(input logic [2:0] o);
        logic [33:0] want;
        @(posedge clk_sys) rd_en <= 1;
        op <= o;
        wr_en <= 1'($urandom);
        wd <= $urandom;
        @(posedge clk_sys) rd_en <= 0;
        wr_en <= 0;
        want = exp_word();
        #1 n_tests++;
        if ({rd_valid, rd_hit, rd_data} !== want) begin
            err_count++;
            $display("Error %0t got %h exp %h", $time,
                {rd_valid, rd_hit, rd_data}, want);
        end
    endtask
    initial begin
        #20us err_count++;
        summarize;
    end
    initial begin
        void'($urandom(32'hbd94));
        repeat (10) @(posedge clk_sys);
        resetn <= 1;
        repeat (3) @(posedge clk_sys);
        setg(16'hf000);
        for (int o = 0; o < 8; o++) rd(3'(o)); // absent
        setg(16'h0bbb);
        for (int o = 0; o < 8; o++) rd(3'(o)); // fitted
        $display("corner test done");
        repeat (60) begin
            setg({4'($urandom), cap(), cap(), cap()});
            rd(3'($urandom)); // random geometry
        end
        $display("random test done");
        @(posedge clk_sys) resetn <= 0;
        #1 n_tests++;
        if ({rd_valid, rd_hit, rd_data} !== 34'h0) begin // reset zero
            err_count++;
            $display("Error %0t got %h exp %h", $time,
                {rd_valid, rd_hit, rd_data}, 34'h0);
        end
        repeat (3) @(posedge clk_sys);
        resetn <= 1;
        repeat (4) @(posedge clk_sys);
        rd(3'h1); // recapture after reset
        rd(3'h2); // recapture after reset
        $display("reset test done");
        summarize;
    end
endmodule // cgi_geometry_regs_tb

// ==== hdl/cgi_geometry_regs.v ====
// Function
// R1: Bit 14 of the cache geometry word reads 0 with a data cache, 1 without.
// R2: Bits 13:12 of the cache geometry word always read 2'b10 (eight words).
// R3: Bits 9:6 report the fitted instruction cache capacity code.
// R4: Bits 5:3 report four-way (3'b010) when an instruction cache is fitted.
// R5: Bit 2 reads 0 with an instruction cache and 1 without.
// R6: Bits 1:0 of the cache geometry word always read 2'b10 (eight words).
// R7: Presence and capacity come from inputs driven by the cache block.
// R8: A register 0 read with secondary opcode 2 returns the RAM size word.
// R9: Bits 21:18 and 9:6 carry data and instruction RAM capacity codes.
// R10: Bit 14 of the RAM size word reads 1 when no data RAM is fitted.
// R11: Bit 2 of the RAM size word reads 1 when no instruction RAM is fitted.
// R12: Reserved bits read zero and writes change nothing.
`include "cgi_consts.vh"

module cgi_geometry_regs (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        resetn,
    // Coprocessor register 0 read port
    input  wire        rd_en,
    input  wire [2:0]  rd_opcode2,
    input  wire        wr_en,
    input  wire [31:0] wr_data,
    // Geometry from cache and memory blocks
    input  wire        dcache_absent_flag,
    input  wire        icache_absent_flag,
    input  wire [3:0]  icache_capacity_code,
    input  wire        data_ram_absent_flag,
    input  wire [3:0]  data_ram_capacity_code,
    input  wire        instr_ram_absent_flag,
    input  wire [3:0]  instr_ram_capacity_code,
    // Read answer
    output reg  [31:0] rd_data,
    output reg         rd_valid,
    output reg         rd_hit
);

    // ----------------------------------------------------------------
    // Field widths and capture layout
    // ----------------------------------------------------------------
    localparam WORD_W = 32;
    localparam CAP_W  = 4;
    localparam WAYS_W = 3;
    localparam LINE_W = 2;
    localparam SEL_W  = 3;
    localparam GEO_W  = 16;

    // Position of each strap inside the captured vector.
    localparam G_DC_ABS = 15;
    localparam G_IC_ABS = 14;
    localparam G_IC_CAP = 10;
    localparam G_DR_ABS = 9;
    localparam G_DR_CAP = 5;
    localparam G_IR_ABS = 4;
    localparam G_IR_CAP = 0;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function sel_is_cache;
        input [SEL_W-1:0] opcode;
        begin
            sel_is_cache = (opcode == `CGI_SEL_CACHE);
        end
    endfunction

    function sel_is_ram;
        input [SEL_W-1:0] opcode;
        begin
            sel_is_ram = (opcode == `CGI_SEL_RAM);
        end
    endfunction

    // Any other secondary opcode names a word kept outside this block.
    function sel_hit;
        input [SEL_W-1:0] opcode;
        begin
            sel_hit = sel_is_cache(opcode) | sel_is_ram(opcode);
        end
    endfunction

    // An absent cache reports zero size so that software ignores it.
    function [CAP_W-1:0] cap_if_fitted;
        input             absent;
        input [CAP_W-1:0] code;
        begin
            cap_if_fitted = absent ? `CGI_CAP_NONE : code;
        end
    endfunction

    function [WAYS_W-1:0] ways_if_fitted;
        input absent;
        begin
            ways_if_fitted = absent ? `CGI_WAYS_NONE : `CGI_WAYS_FOUR;
        end
    endfunction

    // ----------------------------------------------------------------
    // Geometry input capture
    // ----------------------------------------------------------------
    // The straps may be tied at pins by a wrapper, so every bit passes
    // two flip-flops before any logic looks at it.
    wire [GEO_W-1:0] geo_raw;
    wire [GEO_W-1:0] geo_sync;

    // R7 inputs from blocks
    assign geo_raw[G_DC_ABS]                  = dcache_absent_flag;
    assign geo_raw[G_IC_ABS]                  = icache_absent_flag;
    assign geo_raw[G_IC_CAP+CAP_W-1:G_IC_CAP] = icache_capacity_code;
    assign geo_raw[G_DR_ABS]                  = data_ram_absent_flag;
    assign geo_raw[G_DR_CAP+CAP_W-1:G_DR_CAP] = data_ram_capacity_code;
    assign geo_raw[G_IR_ABS]                  = instr_ram_absent_flag;
    assign geo_raw[G_IR_CAP+CAP_W-1:G_IR_CAP] = instr_ram_capacity_code;

    // Each strap bit gets its own two-stage chain.
    genvar gi;
    generate
        for (gi = 0; gi < GEO_W; gi = gi + 1) begin : g_sync
            reg meta_bit;
            reg sync_bit;

            always @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    meta_bit <= 1'b0;
                    sync_bit <= 1'b0;
                end else begin
                    meta_bit <= geo_raw[gi];
                    sync_bit <= meta_bit;
                end
            end

            assign geo_sync[gi] = sync_bit;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Steadiness filter
    // ----------------------------------------------------------------
    // Per-bit synchronisers may resolve the bits of one code on
    // different edges; only a vector seen twice alike is passed on,
    // so a read never sees a capacity code torn between two values.
    reg  [GEO_W-1:0] geo_prev;
    reg  [GEO_W-1:0] geo_hold;
    reg  [GEO_W-1:0] next_geo_hold;
    wire             geo_steady;

    assign geo_steady = (geo_sync == geo_prev);

    always @* begin
        next_geo_hold = geo_hold;
        if (geo_steady) begin
            next_geo_hold = geo_sync;
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            geo_prev <= `CGI_STRAP_RESET;
            geo_hold <= `CGI_STRAP_RESET;
        end else begin
            geo_prev <= geo_sync;
            geo_hold <= next_geo_hold;
        end
    end

    // ----------------------------------------------------------------
    // Settled geometry fields
    // ----------------------------------------------------------------
    // Fields are cut from the held vector, never from the raw straps.
    wire              s_dc_abs;
    wire              s_ic_abs;
    wire [CAP_W-1:0]  s_ic_cap;
    wire              s_dr_abs;
    wire [CAP_W-1:0]  s_dr_cap;
    wire              s_ir_abs;
    wire [CAP_W-1:0]  s_ir_cap;

    assign s_dc_abs = geo_hold[G_DC_ABS];
    assign s_ic_abs = geo_hold[G_IC_ABS];
    assign s_ic_cap = geo_hold[G_IC_CAP+CAP_W-1:G_IC_CAP];
    assign s_dr_abs = geo_hold[G_DR_ABS];
    assign s_dr_cap = geo_hold[G_DR_CAP+CAP_W-1:G_DR_CAP];
    assign s_ir_abs = geo_hold[G_IR_ABS];
    assign s_ir_cap = geo_hold[G_IR_CAP+CAP_W-1:G_IR_CAP];

    // Instruction cache fields that depend on presence.
    wire [CAP_W-1:0]  ic_cap_field;
    wire [WAYS_W-1:0] ic_ways_field;

    // R3 capacity when fitted
    assign ic_cap_field  = cap_if_fitted(s_ic_abs, s_ic_cap);
    // R4 four-way when fitted
    assign ic_ways_field = ways_if_fitted(s_ic_abs);

    // ----------------------------------------------------------------
    // Cache geometry word
    // ----------------------------------------------------------------
    reg [WORD_W-1:0] cache_geometry_info;

    always @* begin
        // R12 reserved zero
        cache_geometry_info = `CGI_RESET_WORD;
        // R1 data cache absence
        cache_geometry_info[`CGI_DC_ABSENT_BIT] = s_dc_abs;
        // R2 data line length
        cache_geometry_info[`CGI_DC_LINE_LSB+LINE_W-1:`CGI_DC_LINE_LSB] =
            `CGI_LINE_8_WORDS;
        // R3 instruction cache capacity
        cache_geometry_info[`CGI_IC_CAP_LSB+CAP_W-1:`CGI_IC_CAP_LSB] =
            ic_cap_field;
        // R4 instruction cache ways
        cache_geometry_info[`CGI_IC_WAYS_LSB+WAYS_W-1:`CGI_IC_WAYS_LSB] =
            ic_ways_field;
        // R5 instruction cache absence
        cache_geometry_info[`CGI_IC_ABSENT_BIT] = s_ic_abs;
        // R6 instruction line length
        cache_geometry_info[`CGI_IC_LINE_LSB+LINE_W-1:`CGI_IC_LINE_LSB] =
            `CGI_LINE_8_WORDS;
    end

    // ----------------------------------------------------------------
    // Local RAM size word
    // ----------------------------------------------------------------
    reg [WORD_W-1:0] local_ram_size_info;

    always @* begin
        // R12 reserved zero
        local_ram_size_info = `CGI_RESET_WORD;
        // R9 data RAM capacity
        local_ram_size_info[`CGI_DR_CAP_LSB+CAP_W-1:`CGI_DR_CAP_LSB] =
            s_dr_cap;
        // R10 data RAM absence
        local_ram_size_info[`CGI_DR_ABSENT_BIT] = s_dr_abs;
        // R9 instruction RAM capacity
        local_ram_size_info[`CGI_IR_CAP_LSB+CAP_W-1:`CGI_IR_CAP_LSB] =
            s_ir_cap;
        // R11 instruction RAM absence
        local_ram_size_info[`CGI_IR_ABSENT_BIT] = s_ir_abs;
    end

    // ----------------------------------------------------------------
    // Read select
    // ----------------------------------------------------------------
    // A read of any other secondary opcode still answers, with zero data,
    // so the core never waits on a word that lives outside this block.
    reg [WORD_W-1:0] next_rd_data;
    reg              next_rd_hit;
    reg              next_rd_valid;

    always @* begin
        next_rd_valid = rd_en;
        next_rd_hit   = 1'b0;
        next_rd_data  = `CGI_RESET_WORD;
        if (rd_en) begin
            next_rd_hit = sel_hit(rd_opcode2);
            if (sel_is_cache(rd_opcode2)) begin
                next_rd_data = cache_geometry_info;
            end
            // R8 RAM size word select
            if (sel_is_ram(rd_opcode2)) begin
                next_rd_data = local_ram_size_info;
            end
        end
    end

    // ----------------------------------------------------------------
    // Write path
    // ----------------------------------------------------------------
    // Both words are read-only: a write strobe and its data are taken
    // at the port and dropped, so no write can disturb a reported value.
    // Nothing here holds writable state; the block's only flops capture the straps, filter them for steadiness and hold the read answer.

    // ----------------------------------------------------------------
    // Read answer registers
    // ----------------------------------------------------------------
    // Each answer signal leaves from its own flop, so the core never
    // sees a glitch from the opcode decode.
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= next_rd_valid;
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_hit <= 1'b0;
        end else begin
            rd_hit <= next_rd_hit;
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_data <= `CGI_RESET_WORD;
        end else begin
            rd_data <= next_rd_data;
        end
    end

endmodule // cgi_geometry_regs

// ==== pkg/cgi_consts.vh ====
`ifndef CGI_CONSTS_VH
`define CGI_CONSTS_VH

// ----------------------------------------------------------------
// Register selection by secondary opcode
// ----------------------------------------------------------------
`define CGI_SEL_CACHE      3'h1
`define CGI_SEL_RAM        3'h2

// ----------------------------------------------------------------
// Cache geometry word fields
// ----------------------------------------------------------------
`define CGI_DC_ABSENT_BIT  14
`define CGI_DC_LINE_LSB    12
`define CGI_IC_CAP_LSB     6
`define CGI_IC_WAYS_LSB    3
`define CGI_IC_ABSENT_BIT  2
`define CGI_IC_LINE_LSB    0
`define CGI_LINE_8_WORDS   2'h2
`define CGI_WAYS_FOUR      3'h2
`define CGI_WAYS_NONE      3'h0

// ----------------------------------------------------------------
// Local RAM size word fields
// ----------------------------------------------------------------
`define CGI_DR_CAP_LSB     18
`define CGI_DR_ABSENT_BIT  14
`define CGI_IR_CAP_LSB     6
`define CGI_IR_ABSENT_BIT  2

// ----------------------------------------------------------------
// Capacity codes and reset values
// ----------------------------------------------------------------
`define CGI_CAP_NONE       4'h0
`define CGI_CAP_MAX        4'hb
`define CGI_RESET_WORD     32'h0000_0000
`define CGI_STRAP_RESET    16'h0000

`endif
